/* File: core/sfr_map_pkg.sv */
package sfr_map_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Offsets of the registers this bank acts on
    localparam logic [7:0] OFF_PORT0 = 8'h80;
    localparam logic [7:0] OFF_STACK = 8'h81;
    localparam logic [7:0] OFF_PTR0_LOW = 8'h82;
    localparam logic [7:0] OFF_PTR0_HIGH = 8'h83;
    localparam logic [7:0] OFF_PTR1_LOW = 8'h84;
    localparam logic [7:0] OFF_PTR1_HIGH = 8'h85;
    localparam logic [7:0] OFF_PTR_SELECT = 8'h86;
    localparam logic [7:0] OFF_TIMER0_LOW = 8'h8a;
    localparam logic [7:0] OFF_TIMER1_LOW = 8'h8b;
    localparam logic [7:0] OFF_TIMER0_HIGH = 8'h8c;
    localparam logic [7:0] OFF_TIMER1_HIGH = 8'h8d;
    localparam logic [7:0] OFF_PORT1 = 8'h90;
    localparam logic [7:0] OFF_UART0_CONTROL = 8'h98;
    localparam logic [7:0] OFF_UART0_BUFFER = 8'h99;
    localparam logic [7:0] OFF_PORT2 = 8'ha0;
    localparam logic [7:0] OFF_PORT3 = 8'hb0;
    localparam logic [7:0] OFF_UART1_CONTROL = 8'hc0;
    localparam logic [7:0] OFF_UART1_BUFFER = 8'hc1;
    localparam logic [7:0] OFF_STATUS = 8'hc5;
    localparam logic [7:0] OFF_TIMER2_LOW = 8'hcc;
    localparam logic [7:0] OFF_TIMER2_HIGH = 8'hcd;

    ////////////////////////////////////////////////////////////////////////////
    // Pointer-select fields and write masks
    localparam int SEL_BIT = 0;
    localparam int STEP_EN_BIT = 4;
    localparam int TOGGLE_BIT = 5;
    localparam int DIR0_BIT = 6;
    localparam int DIR1_BIT = 7;
    localparam logic [7:0] PTR_SELECT_WMASK = 8'hf1;
    localparam logic [7:0] FULL_WMASK = 8'hff;
    localparam logic [7:0] NO_WMASK = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] sfr_index(input logic [7:0] a);
        sfr_index = a[6:0];
    endfunction : sfr_index

    // Locations that exist; all others read zero and drop writes
    function automatic logic sfr_present(input logic [7:0] a);
        case (a)
            8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b,
            8'h8c, 8'h8d, 8'h8e, 8'h90, 8'h91, 8'h96, 8'h98, 8'h99, 8'h9d, 8'ha0, 8'ha8, 8'ha9,
            8'haa, 8'hb0, 8'hb1, 8'hb8, 8'hb9, 8'hba, 8'hc0, 8'hc1, 8'hc2, 8'hc4, 8'hc5, 8'hc7,
            8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'hd5, 8'hd6, 8'hd8, 8'he0, 8'he8:
                sfr_present = 1'b1;
            default:
                sfr_present = 1'b0;
        endcase
    endfunction : sfr_present

    // Values after reset; the status the hardware decides elsewhere starts at 8'h10, unlisted locations at zero
    function automatic logic [7:0] sfr_reset(input logic [7:0] a);
        case (a)
            8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc7: sfr_reset = 8'hff;
            8'h81: sfr_reset = 8'h07;
            8'h86: sfr_reset = 8'h04;
            8'h8e: sfr_reset = 8'h01;
            8'h96: sfr_reset = 8'hc7;
            8'h9d: sfr_reset = 8'h1f;
            8'hb1, 8'hb8, 8'hc4: sfr_reset = 8'h80;
            8'hc2: sfr_reset = 8'hf5;
            8'hc5: sfr_reset = 8'h10;
            8'hc9: sfr_reset = 8'hfc;
            8'hd5: sfr_reset = 8'hb0;
            8'he8: sfr_reset = 8'he0;
            default: sfr_reset = 8'h00;
        endcase
    endfunction : sfr_reset

    function automatic logic [7:0] sfr_wmask(input logic [7:0] a);
        case (a)
            OFF_PTR_SELECT: sfr_wmask = PTR_SELECT_WMASK;
            OFF_STATUS: sfr_wmask = NO_WMASK;
            default: sfr_wmask = FULL_WMASK;
        endcase
    endfunction : sfr_wmask

endpackage : sfr_map_pkg

/* File: core/sfr_bank.sv */
`timescale 1ns/100ps
module sfr_bank
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Core register access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_direct,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_op,
    input wire logic [2:0] sfr_bit_sel,
    output logic [7:0] sfr_rdata,
    output logic sfr_rack,
    // Data pointer use by the core
    input wire logic first_address_pointer_step,
    output logic [15:0] first_address_pointer_active,
    output logic first_address_pointer_sel,
    // Port latches and stack pointer
    output logic [7:0] port0_out,
    output logic [7:0] port1_out,
    output logic [7:0] port2_out,
    output logic [7:0] port3_out,
    output logic [7:0] stack_top,
    // Timer images
    output logic [15:0] timer0_value,
    output logic [15:0] timer1_value,
    output logic [15:0] timer2_value,
    // UARTs
    input wire logic [7:0] uart0_rx_data,
    input wire logic [7:0] uart1_rx_data,
    output logic [7:0] uart0_ctrl,
    output logic [7:0] uart1_ctrl,
    output logic [7:0] uart0_tx_data,
    output logic [7:0] uart1_tx_data,
    output logic uart0_tx_strobe,
    output logic uart1_tx_strobe,
    // Processor status
    input wire logic [7:0] status_in
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [127:0][7:0] sfr;
        logic [15:0] active;
        logic [7:0] rdata;
        logic rack;
        logic tx0;
        logic tx1;
    } bank_state_t;

    function automatic bank_state_t build_reset();
        bank_state_t s;
        s = '0;
        for (int i = 0; i < 128; i++)
        begin
            s.sfr[i] = sfr_map_pkg::sfr_reset({1'b1, 7'(i)});
        end
        s.active = {s.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PTR0_HIGH)],
                    s.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PTR0_LOW)]};
        return s;
    endfunction : build_reset

    localparam bank_state_t STATE_RESET = build_reset();
    localparam logic [6:0] I_SEL = sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PTR_SELECT);
    localparam logic [6:0] I_P0L = sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PTR0_LOW);
    localparam logic [6:0] I_P0H = sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PTR0_HIGH);
    localparam logic [6:0] I_P1L = sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PTR1_LOW);
    localparam logic [6:0] I_P1H = sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PTR1_HIGH);
    localparam logic [6:0] I_STATUS = sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_STATUS);

    bank_state_t state_reg;
    bank_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    logic acc_ok;
    logic bit_ok;
    logic [6:0] acc_idx;
    assign acc_idx = sfr_map_pkg::sfr_index(sfr_addr);
    // Indirect accesses go to upper scratchpad, never here
    assign acc_ok = sfr_direct && sfr_addr[7] && sfr_map_pkg::sfr_present(sfr_addr);
    // Bit access only at addresses ending in 0 or 8
    assign bit_ok = (sfr_addr[2:0] == 3'h0);

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic sel;
        logic [15:0] ptr;
        logic [7:0] base;
        logic [7:0] newv;
        logic [7:0] mask;
        logic [7:0] rbyte;
        sel = 1'b0;
        ptr = 16'h0000;
        base = 8'h00;
        newv = 8'h00;
        mask = 8'h00;
        rbyte = 8'h00;
        state_next = state_reg;
        state_next.rack = 1'b0;
        state_next.tx0 = 1'b0;
        state_next.tx1 = 1'b0;
        state_next.sfr[I_STATUS] = status_in;
        // Pointer step after an instruction that used the pointer
        if (first_address_pointer_step)
        begin
            sel = state_reg.sfr[I_SEL][sfr_map_pkg::SEL_BIT];
            ptr = state_reg.active;
            if (state_reg.sfr[I_SEL][sfr_map_pkg::STEP_EN_BIT])
            begin
                if (state_reg.sfr[I_SEL][sel ? sfr_map_pkg::DIR1_BIT : sfr_map_pkg::DIR0_BIT])
                    ptr = ptr - 16'h0001;
                else
                    ptr = ptr + 16'h0001;
                if (sel)
                begin
                    state_next.sfr[I_P1L] = ptr[7:0];
                    state_next.sfr[I_P1H] = ptr[15:8];
                end
                else
                begin
                    state_next.sfr[I_P0L] = ptr[7:0];
                    state_next.sfr[I_P0H] = ptr[15:8];
                end
            end
            if (state_reg.sfr[I_SEL][sfr_map_pkg::TOGGLE_BIT])
                state_next.sfr[I_SEL][sfr_map_pkg::SEL_BIT] = ~sel;
        end
        // Software write lands last, so a colliding step loses to it
        if (sfr_wr && acc_ok && (!sfr_bit_op || bit_ok))
        begin
            base = state_next.sfr[acc_idx];
            newv = sfr_wdata;
            if (sfr_bit_op)
            begin
                newv = base;
                newv[sfr_bit_sel] = sfr_wdata[0];
            end
            mask = sfr_map_pkg::sfr_wmask(sfr_addr);
            // Latches, stack, timer bytes, UART controls hold what was written; pointer select takes only its masked bits
            state_next.sfr[acc_idx] = (base & ~mask) | (newv & mask);
            state_next.tx0 = (sfr_addr == sfr_map_pkg::OFF_UART0_BUFFER);
            state_next.tx1 = (sfr_addr == sfr_map_pkg::OFF_UART1_BUFFER);
        end
        // Reads answer one cycle later; unmapped or indirect read as zero
        if (sfr_rd)
        begin
            state_next.rack = 1'b1;
            if (acc_ok)
            begin
                if (sfr_addr == sfr_map_pkg::OFF_UART0_BUFFER)
                    rbyte = uart0_rx_data;
                else if (sfr_addr == sfr_map_pkg::OFF_UART1_BUFFER)
                    rbyte = uart1_rx_data;
                else
                    rbyte = state_reg.sfr[acc_idx];
            end
            if (!sfr_bit_op)
                state_next.rdata = rbyte;
            else if (bit_ok)
                state_next.rdata = {7'h00, rbyte[sfr_bit_sel]};
            else
                state_next.rdata = 8'h00;
        end
        // Active pointer drives the external-data address
        if (state_next.sfr[I_SEL][sfr_map_pkg::SEL_BIT])
            state_next.active = {state_next.sfr[I_P1H], state_next.sfr[I_P1L]};
        else
            state_next.active = {state_next.sfr[I_P0H], state_next.sfr[I_P0L]};
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= STATE_RESET;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all taken from the state register
    assign sfr_rdata = state_reg.rdata;
    assign sfr_rack = state_reg.rack;
    assign first_address_pointer_active = state_reg.active;
    assign first_address_pointer_sel = state_reg.sfr[I_SEL][sfr_map_pkg::SEL_BIT];
    assign port0_out = state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PORT0)];
    assign port1_out = state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PORT1)];
    assign port2_out = state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PORT2)];
    assign port3_out = state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_PORT3)];
    assign stack_top = state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_STACK)];
    assign timer0_value = {state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_TIMER0_HIGH)],
                           state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_TIMER0_LOW)]};
    assign timer1_value = {state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_TIMER1_HIGH)],
                           state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_TIMER1_LOW)]};
    assign timer2_value = {state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_TIMER2_HIGH)],
                           state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_TIMER2_LOW)]};
    assign uart0_ctrl = state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_UART0_CONTROL)];
    assign uart1_ctrl = state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_UART1_CONTROL)];
    assign uart0_tx_data = state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_UART0_BUFFER)];
    assign uart1_tx_data = state_reg.sfr[sfr_map_pkg::sfr_index(sfr_map_pkg::OFF_UART1_BUFFER)];
    assign uart0_tx_strobe = state_reg.tx0;
    assign uart1_tx_strobe = state_reg.tx1;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic wr_any_ptr;
    logic wr_sel;
    assign wr_sel = sfr_wr && sfr_direct && (sfr_addr == sfr_map_pkg::OFF_PTR_SELECT);
    assign wr_any_ptr = sfr_wr && sfr_direct && (sfr_addr[7:3] == 5'h10) && (sfr_addr[2:0] >= 3'h2);

    a_active_follows_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        first_address_pointer_active == (first_address_pointer_sel ? {state_reg.sfr[I_P1H], state_reg.sfr[I_P1L]}
                                 : {state_reg.sfr[I_P0H], state_reg.sfr[I_P0L]}))
        else $error("active pointer does not match selection");

    a_sel_auto_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
        (first_address_pointer_step && state_reg.sfr[I_SEL][sfr_map_pkg::TOGGLE_BIT] && !wr_sel) |=> (first_address_pointer_sel != $past(first_address_pointer_sel)))
        else $error("selection did not toggle after pointer use");

    a_sel_no_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
        (!first_address_pointer_step && !wr_sel) |=> $stable(first_address_pointer_sel))
        else $error("selection changed without cause");

    a_ptr_increment: assert property (@(posedge mclk) disable iff (!rst_n)
        (first_address_pointer_step && state_reg.sfr[I_SEL][sfr_map_pkg::STEP_EN_BIT] && !wr_any_ptr && !wr_sel
         && !state_reg.sfr[I_SEL][sfr_map_pkg::TOGGLE_BIT]
         && !state_reg.sfr[I_SEL][first_address_pointer_sel ? sfr_map_pkg::DIR1_BIT : sfr_map_pkg::DIR0_BIT])
        |=> (first_address_pointer_active == $past(first_address_pointer_active) + 16'h0001))
        else $error("active pointer did not increment");

    a_ptr_decrement: assert property (@(posedge mclk) disable iff (!rst_n)
        (first_address_pointer_step && state_reg.sfr[I_SEL][sfr_map_pkg::STEP_EN_BIT] && !wr_any_ptr && !wr_sel
         && !state_reg.sfr[I_SEL][sfr_map_pkg::TOGGLE_BIT]
         && state_reg.sfr[I_SEL][first_address_pointer_sel ? sfr_map_pkg::DIR1_BIT : sfr_map_pkg::DIR0_BIT])
        |=> (first_address_pointer_active == $past(first_address_pointer_active) - 16'h0001))
        else $error("active pointer did not decrement");

    a_stack_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (sfr_wr && sfr_direct && !sfr_bit_op && sfr_addr == sfr_map_pkg::OFF_STACK)
        |=> (stack_top == $past(sfr_wdata)) ##1 ((stack_top == $past(sfr_wdata, 2)) || $past(sfr_wr)))
        else $error("stack pointer lost written value");

    a_port_latch: assert property (@(posedge mclk) disable iff (!rst_n)
        (sfr_wr && sfr_direct && !sfr_bit_op && sfr_addr == sfr_map_pkg::OFF_PORT1) |=> (port1_out == $past(sfr_wdata)))
        else $error("port latch did not take written value");

    a_timer_high: assert property (@(posedge mclk) disable iff (!rst_n)
        (sfr_wr && sfr_direct && !sfr_bit_op && sfr_addr == sfr_map_pkg::OFF_TIMER0_HIGH)
        |=> (timer0_value[15:8] == $past(sfr_wdata)) && $stable(timer0_value[7:0]))
        else $error("timer high byte write went astray");

    a_uart_send: assert property (@(posedge mclk) disable iff (!rst_n)
        (sfr_wr && sfr_direct && !sfr_bit_op && sfr_addr == sfr_map_pkg::OFF_UART0_BUFFER)
        |=> uart0_tx_strobe && (uart0_tx_data == $past(sfr_wdata)) ##1 !uart0_tx_strobe || $past(sfr_wr))
        else $error("uart send strobe wrong");

    a_uart_receive: assert property (@(posedge mclk) disable iff (!rst_n)
        (sfr_rd && sfr_direct && !sfr_bit_op && sfr_addr == sfr_map_pkg::OFF_UART1_BUFFER)
        |=> sfr_rack && (sfr_rdata == $past(uart1_rx_data)))
        else $error("uart buffer read did not return received data");

    a_uart_control: assert property (@(posedge mclk) disable iff (!rst_n)
        (sfr_wr && sfr_direct && !sfr_bit_op && sfr_addr == sfr_map_pkg::OFF_UART1_CONTROL)
        |=> (uart1_ctrl == $past(sfr_wdata)))
        else $error("uart control write lost");

    a_indirect_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
        (sfr_wr && !sfr_direct) |=> $stable(port0_out) && $stable(stack_top) && $stable(uart0_ctrl))
        else $error("indirect access changed a register");

    a_bit_refused: assert property (@(posedge mclk) disable iff (!rst_n)
        (sfr_wr && sfr_bit_op && sfr_addr == sfr_map_pkg::OFF_STACK) |=> $stable(stack_top))
        else $error("bit write reached a register not bit addressable");

    c_toggle: cover property (@(posedge mclk) disable iff (!rst_n)
        first_address_pointer_step && state_reg.sfr[I_SEL][sfr_map_pkg::TOGGLE_BIT] ##1 first_address_pointer_step);
    c_step: cover property (@(posedge mclk) disable iff (!rst_n)
        first_address_pointer_step && state_reg.sfr[I_SEL][sfr_map_pkg::STEP_EN_BIT]);
    c_bit_write: cover property (@(posedge mclk) disable iff (!rst_n)
        sfr_wr && sfr_bit_op && bit_ok && acc_ok);
    c_uart_tx: cover property (@(posedge mclk) disable iff (!rst_n) uart0_tx_strobe ##1 uart1_tx_strobe);

endmodule : sfr_bank

/* File: tb/core_model.sv */
`timescale 1ns/100ps
module core_model
(
    // Clock
    input wire logic mclk,
    // Register access
    output logic [7:0] sfr_addr,
    output logic sfr_direct,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic [7:0] sfr_wdata,
    output logic sfr_bit_op,
    output logic [2:0] sfr_bit_sel,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rack,
    // Pointer use
    output logic first_address_pointer_step
);
    logic got_rack;

    initial
    begin
        sfr_addr = 8'h00;
        sfr_direct = 1'b0;
        sfr_rd = 1'b0;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        sfr_bit_op = 1'b0;
        sfr_bit_sel = 3'h0;
        first_address_pointer_step = 1'b0;
        got_rack = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request holds for the taking edge only; idle direct, address and data lines carry the inverse so a stale value is never mistaken
    task automatic access(input logic rd, input logic wr, input logic dir, input logic bop, input logic [2:0] bsel,
                          input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rdata);
        @(posedge mclk);
        sfr_rd <= rd;
        sfr_wr <= wr;
        sfr_direct <= dir;
        sfr_bit_op <= bop;
        sfr_bit_sel <= bsel;
        sfr_addr <= addr;
        sfr_wdata <= data;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        sfr_wr <= 1'b0;
        sfr_direct <= ~dir;
        sfr_bit_op <= 1'b0;
        sfr_addr <= ~addr;
        sfr_wdata <= ~data;
        #1;
        got_rack = sfr_rack;
        rdata = sfr_rdata;
    endtask : access

    // Step pulse lasting n edges, so n above one gives back-to-back steps
    task automatic step(input int n);
        @(posedge mclk);
        first_address_pointer_step <= 1'b1;
        repeat (n) @(posedge mclk);
        first_address_pointer_step <= 1'b0;
        #1;
    endtask : step
endmodule : core_model

/* File: tb/sfr_map_and_data_pointers_test.sv */
`timescale 1ns/100ps
module sfr_map_and_data_pointers_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] uart0_rx_data = 8'h00;
    logic [7:0] uart1_rx_data = 8'h00;
    logic [7:0] status_in = 8'h00;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port0_out, port1_out, port2_out, port3_out, stack_top;
    logic [7:0] uart0_ctrl, uart1_ctrl, uart0_tx_data, uart1_tx_data, a, v, d, ctl;
    logic sfr_direct, sfr_rd, sfr_wr, sfr_bit_op, sfr_rack, first_address_pointer_step, first_address_pointer_sel, uart0_tx_strobe, uart1_tx_strobe;
    logic [2:0] sfr_bit_sel;
    logic [15:0] first_address_pointer_active, timer0_value, timer1_value, timer2_value;
    logic [15:0] p [2];
    logic [8:0] vw;
    logic sel;
    int n, compares = 0, fails = 0;
    logic [7:0] rst_list [17] = '{8'h80, 8'h81, 8'h82, 8'h85, 8'h86, 8'h8a, 8'h8d, 8'h8e, 8'h90, 8'h98, 8'ha0,
                                  8'hb0, 8'hc0, 8'hc2, 8'hcd, 8'he8, 8'hf0};
    logic [7:0] rw_list [15] = '{8'h80, 8'h81, 8'h84, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h98, 8'ha0, 8'hb0,
                                 8'hc0, 8'hcc, 8'hcd, 8'h83};

    always #20 mclk = ~mclk;

    sfr_bank DUT (.mclk, .rst_n, .sfr_addr, .sfr_direct, .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_bit_op, .sfr_bit_sel,
        .sfr_rdata, .sfr_rack, .first_address_pointer_step, .first_address_pointer_active, .first_address_pointer_sel, .port0_out, .port1_out, .port2_out,
        .port3_out, .stack_top, .timer0_value, .timer1_value, .timer2_value, .uart0_rx_data, .uart1_rx_data,
        .uart0_ctrl, .uart1_ctrl, .uart0_tx_data, .uart1_tx_data, .uart0_tx_strobe, .uart1_tx_strobe, .status_in);
    core_model core (.mclk, .sfr_addr, .sfr_direct, .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_bit_op, .sfr_bit_sel,
        .sfr_rdata, .sfr_rack, .first_address_pointer_step);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_reset(input logic [7:0] x);
        case (x)
            8'h80, 8'h90, 8'ha0, 8'hb0: return 8'hff;
            8'h81: return 8'h07;
            8'h86: return 8'h04;
            8'h8e: return 8'h01;
            8'hc2: return 8'hf5;
            8'he8: return 8'he0;
            default: return 8'h00;
        endcase
    endfunction : exp_reset

    // Output image of a location; top bit says whether it has one
    function automatic logic [8:0] view(input logic [7:0] x);
        case (x)
            8'h80: return {1'b1, port0_out};
            8'h90: return {1'b1, port1_out};
            8'ha0: return {1'b1, port2_out};
            8'hb0: return {1'b1, port3_out};
            8'h81: return {1'b1, stack_top};
            8'h8a: return {1'b1, timer0_value[7:0]};
            8'h8c: return {1'b1, timer0_value[15:8]};
            8'h8b: return {1'b1, timer1_value[7:0]};
            8'h8d: return {1'b1, timer1_value[15:8]};
            8'hcc: return {1'b1, timer2_value[7:0]};
            8'hcd: return {1'b1, timer2_value[15:8]};
            8'h98: return {1'b1, uart0_ctrl};
            8'hc0: return {1'b1, uart1_ctrl};
            default: return 9'h000;
        endcase
    endfunction : view

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] x, input logic [7:0] y);
        core.access(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, x, y, d);
    endtask : wr

    task automatic rd(input logic [7:0] x, output logic [7:0] y);
        core.access(1'b1, 1'b0, 1'b1, 1'b0, 3'h0, x, 8'h00, y);
        chk("read ack", 16'h0001, 16'(core.got_rack));
    endtask : rd

    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(97));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk("port0 after reset", 16'h00ff, 16'(port0_out));
        chk("stack after reset", 16'h0007, 16'(stack_top));
        foreach (rst_list[i])
        begin
            rd(rst_list[i], d);
            chk("reset value", 16'(exp_reset(rst_list[i])), 16'(d));
        end
        for (int i = 0; i < 40; i++)
        begin
            a = rw_list[$urandom_range(14)];
            v = 8'($urandom);
            wr(a, v);
            vw = view(a);
            if (vw[8])
                chk("output image", 16'(v), 16'(vw[7:0]));
            rd(a, d);
            chk("read back", 16'(v), 16'(d));
        end
        for (int u = 0; u < 2; u++)
        begin
            a = u ? 8'hc1 : 8'h99;
            v = 8'($urandom);
            wr(a, v);
            chk("tx strobe", 16'h0001, 16'(u ? uart1_tx_strobe : uart0_tx_strobe));
            chk("tx data", 16'(v), 16'(u ? uart1_tx_data : uart0_tx_data));
            uart0_rx_data <= 8'($urandom);
            uart1_rx_data <= 8'($urandom);
            rd(a, d);
            chk("rx data", 16'(u ? uart1_rx_data : uart0_rx_data), 16'(d));
        end
        wr(8'h80, 8'h3c);
        core.access(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h80, 8'hc3, d);
        chk("indirect write", 16'h003c, 16'(port0_out));
        core.access(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'h80, 8'h00, d);
        chk("indirect read", 16'h0000, 16'(d));
        rd(8'h20, d);
        chk("low address read", 16'h0000, 16'(d));
        wr(8'h90, 8'hff);
        core.access(1'b0, 1'b1, 1'b1, 1'b1, 3'h3, 8'h90, 8'h00, d);
        chk("bit write", 16'h00f7, 16'(port1_out));
        core.access(1'b1, 1'b0, 1'b1, 1'b1, 3'h2, 8'h90, 8'h00, d);
        chk("bit read", 16'h0001, 16'(d));
        wr(8'h81, 8'h55);
        core.access(1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 8'h81, 8'h00, d);
        chk("bit write refused", 16'h0055, 16'(stack_top));
        core.access(1'b1, 1'b0, 1'b1, 1'b1, 3'h0, 8'h81, 8'h00, d);
        chk("bit read refused", 16'h0000, 16'(d));
        status_in <= 8'($urandom);
        wr(8'hc5, ~status_in);
        rd(8'hc5, d);
        chk("status", 16'(status_in), 16'(d));
        for (int i = 0; i < 12; i++)
        begin
            p[0] = (i == 0) ? 16'hffff : 16'($urandom);
            p[1] = (i == 1) ? 16'h0000 : 16'($urandom);
            ctl = (i == 0) ? 8'h30 : (i == 1) ? 8'hb1 : 8'($urandom) & 8'hf1;
            wr(8'h82, p[0][7:0]);
            wr(8'h83, p[0][15:8]);
            wr(8'h84, p[1][7:0]);
            wr(8'h85, p[1][15:8]);
            wr(8'h86, ctl);
            sel = ctl[0];
            chk("select", 16'(sel), 16'(first_address_pointer_sel));
            chk("active pointer", p[sel], first_address_pointer_active);
            n = 1 + i % 2;
            core.step(n);
            // Each step uses the selection in force before its own toggle
            for (int k = 0; k < n; k++)
            begin
                if (ctl[4])
                    p[sel] = ctl[6 + int'(sel)] ? p[sel] - 16'h0001 : p[sel] + 16'h0001;
                if (ctl[5])
                    sel = ~sel;
            end
            chk("select after step", 16'(sel), 16'(first_address_pointer_sel));
            chk("pointer after step", p[sel], first_address_pointer_active);
            rd(8'h86, d);
            chk("select readback", 16'({ctl[7:4], 3'b010, sel}), 16'(d));
            rd(8'h82, d);
            chk("pointer0 low", 16'(p[0][7:0]), 16'(d));
        end
        print_verdict();
    end
endmodule : sfr_map_and_data_pointers_test
